// >>> include/ddr_init_pkg.sv
/*
  Constants, timing figures, command codes, register map and sequencer
  states of the DDR memory initialisation controller.
  Assumes a 200 MHz system clock; every memory time but the DLL read wait is turned into cycles here.
*/
package ddr_init_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int CLK_PS = 5000;
  localparam int CK_DIV = 4;
  localparam int CK_HALF = CK_DIV / 2;

  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_up(input int ps);
    return (ps + CLK_PS - 1) / CLK_PS;
  endfunction

  function automatic int cyc_dn(input int ps);
    return (ps / CLK_PS < 1) ? 1 : ps / CLK_PS;
  endfunction

  // ----------------------------------------------------------------
  // memory timing
  // ----------------------------------------------------------------
  localparam int T_POWERUP_US = 200;
  localparam int POWERUP_CYC = cyc_up(T_POWERUP_US * 1000000);
  localparam int T_RP_NS = 20;
  localparam int RP_CYC = cyc_up(T_RP_NS * 1000);
  localparam int T_RFC_NS = 75;
  localparam int RFC_CYC = cyc_up(T_RFC_NS * 1000);
  localparam int T_RAS_NS = 40;
  localparam int RAS_CYC = cyc_up(T_RAS_NS * 1000);
  localparam int T_MRD_CK = 2;
  localparam int MRD_CYC = T_MRD_CK * CK_DIV;
  localparam int DLL_READ_CK = 200;
  localparam int T_REFI_PS = 7812500;
  localparam int REFI_CYC = cyc_dn(T_REFI_PS);

  localparam int TMR_W = 16;
  typedef logic [TMR_W-1:0] tmr_type;

  // ----------------------------------------------------------------
  // command pins {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam logic [1:0] BA_BASE_MODE = 2'h0;
  localparam logic [1:0] BA_EXT_MODE = 2'h1;
  localparam int AP_BIT = 10;
  localparam int DLL_RESET_BIT = 8;
  localparam int DLL_DISABLE_BIT = 0;
  localparam int DRIVE_STRENGTH_BIT = 1;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_CMD = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int CTRL_START = 0;
  localparam int CTRL_REDUCED_DRIVE = 1;
  localparam int CTRL_DLL_CLEAR = 2;
  localparam int CTRL_RELOCK = 3;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_BA_LSB = 4;
  localparam int CMD_ADDR_LSB = 6;
  localparam int CMD_W = 19;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0061;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_POWER = 11'h002,
    ST_PRE1 = 11'h004,
    ST_EXT_MODE = 11'h008,
    ST_BASE_MODE = 11'h010,
    ST_PRE2 = 11'h020,
    ST_REF1 = 11'h040,
    ST_REF2 = 11'h080,
    ST_DLL_CLEAR = 11'h100,
    ST_WAIT = 11'h200,
    ST_READY = 11'h400
  } seq_state_type;

endpackage

// >>> logic/ddr_clock_divider.sv
/*
  Divides the system clock down to the memory clock pair and marks the
  cycle in which the memory clock falls, where commands may change.
  Assumes it runs from reset onward without gaps.
*/
`timescale 1ns/1ps
module ddr_clock_divider (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // memory clock
  output logic o_ck,
  output logic o_ck_n,
  output logic o_tick
);

  logic [3:0] count;
  logic [3:0] next_count;

  assign next_count = (count == 4'(ddr_init_pkg::CK_DIV - 1)) ? 4'h0 : count + 4'h1;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count <= 4'h0;
      o_ck <= 1'b1;
      o_ck_n <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      count <= next_count;
      o_ck <= next_count < 4'(ddr_init_pkg::CK_HALF);
      o_ck_n <= !(next_count < 4'(ddr_init_pkg::CK_HALF));
      o_tick <= next_count == 4'(ddr_init_pkg::CK_HALF);
    end
  end

endmodule

// >>> logic/ddr_wait_timer.sv
/*
  Loadable down counter; done while the count stands at zero.
  Assumes a load never coincides with a wanted decrement.
*/
`timescale 1ns/1ps
module ddr_wait_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_value,
  input wire logic i_en,
  // status
  output logic o_done
);

  logic [W-1:0] count;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count <= '0;
    end else if (i_load) begin
      count <= i_value;
    end else if (i_en && count != '0) begin
      count <= count - W'(1);
    end
  end

  assign o_done = count == '0;

endmodule

// >>> logic/ddr_init_controller.sv
/*
  Memory-side controller that powers up and initialises a single-rank DDR
  module, then refreshes it and passes single software commands to it.
  Assumes software on an AXI4-Lite port and a module wired to the pins.
*/
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
// Summary of operation
// - hold clock enable low 200us, clock running
// - raise clock enable, then one no-operation
// - precharge all, then row-precharge wait
// - load extended mode: DLL on, drive select
// - mode-set wait after every mode load; software-command mode loads get none
// - base mode with DLL reset; 200 cycles
// - second precharge all, row-precharge wait
// - two auto refreshes, each refresh-cycle wait
// - optional base mode load clearing DLL reset
// - auto-precharge only after active-to-precharge time
// - clock enable high throughout every refresh
// - relock DLL, 200 cycles before reads
// - refresh every average interval; one due during a relock's mode-set wait is held until that wait ends
`timescale 1ns/1ps
module ddr_init_controller #(
  parameter int POWERUP_CYC = ddr_init_pkg::POWERUP_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // axi write address and data
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi read
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // memory pins
  output logic o_mem_ck,
  output logic o_mem_ck_n,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_ba,
  output logic [12:0] o_addr
);

  // ----------------------------------------------------------------
  // clock and timers
  // ----------------------------------------------------------------
  logic tick;
  logic wait_load, wait_done, dll_load, dll_done, ras_load, ras_done, refi_load, refi_done;
  ddr_init_pkg::tmr_type wait_val;

  ddr_clock_divider u_div (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .o_ck(o_mem_ck),
    .o_ck_n(o_mem_ck_n),
    .o_tick(tick)
  );

  ddr_wait_timer #(.W(ddr_init_pkg::TMR_W)) u_wait (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(wait_load),
    .i_value(wait_val),
    .i_en(1'b1),
    .o_done(wait_done)
  );

  // counts memory clocks from the DLL reset load
  ddr_wait_timer #(.W(ddr_init_pkg::TMR_W)) u_dll (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(dll_load),
    .i_value(ddr_init_pkg::tmr_type'(ddr_init_pkg::DLL_READ_CK)),
    .i_en(tick),
    .o_done(dll_done)
  );

  ddr_wait_timer #(.W(ddr_init_pkg::TMR_W)) u_ras (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(ras_load),
    .i_value(ddr_init_pkg::tmr_type'(ddr_init_pkg::RAS_CYC)),
    .i_en(1'b1),
    .o_done(ras_done)
  );

  ddr_wait_timer #(.W(ddr_init_pkg::TMR_W)) u_refi (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(refi_load),
    .i_value(ddr_init_pkg::tmr_type'(ddr_init_pkg::REFI_CYC)),
    .i_en(1'b1),
    .o_done(refi_done)
  );

  // ----------------------------------------------------------------
  // axi handshakes
  // ----------------------------------------------------------------
  logic [31:0] awaddr, wdata, wmask;
  logic [3:0] wstrb;
  logic wr_fire, wr_ok, rd_ok;

  assign wr_fire = !o_awready && !o_wready && !o_bvalid;
  assign wr_ok = awaddr[31:4] == 28'h0 && awaddr[1:0] == 2'h0;
  assign rd_ok = i_araddr[31:4] == 28'h0 && i_araddr[1:0] == 2'h0;

  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= ddr_init_pkg::RESP_OKAY;
      awaddr <= 32'h0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        awaddr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        wdata <= i_wdata;
        wstrb <= i_wstrb;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? ddr_init_pkg::RESP_OKAY : ddr_init_pkg::RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] wbits;
  logic start_pulse, reduced_drive, dll_clear_en, relock_req, relock_take;
  logic cmd_pending, cmd_issue, init_done;
  logic [12:0] mode_bits;
  logic [ddr_init_pkg::CMD_W-1:0] cmd_word;
  logic [3:0] cmd_code;
  logic [1:0] cmd_ba;
  logic [12:0] cmd_addr;
  ddr_init_pkg::seq_state_type state, ret;

  assign wbits = wdata & wmask;
  assign cmd_code = cmd_word[ddr_init_pkg::CMD_CODE_LSB +: 4];
  assign cmd_ba = cmd_word[ddr_init_pkg::CMD_BA_LSB +: ddr_init_pkg::BA_W];
  assign cmd_addr = cmd_word[ddr_init_pkg::CMD_ADDR_LSB +: ddr_init_pkg::ADDR_W];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      start_pulse <= 1'b0;
      reduced_drive <= 1'b0;
      dll_clear_en <= 1'b0;
      relock_req <= 1'b0;
      mode_bits <= ddr_init_pkg::MODE_RESET;
      cmd_word <= '0;
      cmd_pending <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      if (relock_take) begin
        relock_req <= 1'b0;
      end
      if (cmd_issue) begin
        cmd_pending <= 1'b0;
      end
      if (wr_fire && wr_ok) begin
        unique case (awaddr[3:0])
          ddr_init_pkg::OFS_CTRL: begin
            start_pulse <= wbits[ddr_init_pkg::CTRL_START];
            if (wstrb[0]) begin
              reduced_drive <= wdata[ddr_init_pkg::CTRL_REDUCED_DRIVE];
              dll_clear_en <= wdata[ddr_init_pkg::CTRL_DLL_CLEAR];
            end
            if (wbits[ddr_init_pkg::CTRL_RELOCK] && init_done) begin
              relock_req <= 1'b1;
            end
          end
          ddr_init_pkg::OFS_MODE: begin
            mode_bits <= (mode_bits & ~wmask[12:0]) | wbits[12:0];
          end
          ddr_init_pkg::OFS_CMD: begin
            if (!cmd_pending && init_done) begin
              cmd_word <= wbits[ddr_init_pkg::CMD_W-1:0];
              cmd_pending <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic read_block, ap_block;
  assign read_block = !dll_done;
  assign ap_block = !ras_done;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= ddr_init_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= rd_ok ? ddr_init_pkg::RESP_OKAY : ddr_init_pkg::RESP_SLVERR;
      o_rdata <= 32'h0;
      if (rd_ok) begin
        unique case (i_araddr[3:0])
          ddr_init_pkg::OFS_CTRL: begin
            o_rdata <= {28'h0, relock_req, dll_clear_en, reduced_drive, 1'b0};
          end
          ddr_init_pkg::OFS_MODE: begin
            o_rdata <= {19'h0, mode_bits};
          end
          ddr_init_pkg::OFS_CMD: begin
            o_rdata <= {13'h0, cmd_word};
          end
          default: begin
            o_rdata <= {26'h0, o_cke, state == ddr_init_pkg::ST_POWER, ap_block, read_block,
                        cmd_pending, init_done};
          end
        endcase
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  ddr_init_pkg::seq_state_type next_state, next_ret;
  logic [3:0] next_cmd;
  logic [1:0] next_ba;
  logic [12:0] next_addr, base_mode;
  logic next_cke, cmd_allowed, issue;

  assign base_mode = mode_bits & ~(13'h1 << ddr_init_pkg::DLL_RESET_BIT);
  assign cmd_allowed = !(cmd_code == ddr_init_pkg::CMD_READ && read_block)
    && !((cmd_code == ddr_init_pkg::CMD_READ || cmd_code == ddr_init_pkg::CMD_WRITE)
    && cmd_addr[ddr_init_pkg::AP_BIT] && ap_block);

  always_comb begin
    next_state = state;
    next_ret = ret;
    next_cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
    next_ba = o_ba;
    next_addr = o_addr;
    next_cke = o_cke;
    wait_load = 1'b0;
    wait_val = '0;
    dll_load = 1'b0;
    ras_load = 1'b0;
    refi_load = 1'b0;
    cmd_issue = 1'b0;
    relock_take = 1'b0;
    issue = 1'b0;
    if (tick) begin
      next_cmd = ddr_init_pkg::CMD_NOP;
    end
    unique case (state)
      ddr_init_pkg::ST_IDLE: begin
        if (start_pulse) begin
          next_state = ddr_init_pkg::ST_POWER;
          wait_load = 1'b1;
          wait_val = ddr_init_pkg::tmr_type'(POWERUP_CYC);
        end
      end
      ddr_init_pkg::ST_POWER: begin
        if (tick && wait_done) begin
          next_cke = 1'b1;
          next_state = ddr_init_pkg::ST_PRE1;
        end
      end
      ddr_init_pkg::ST_PRE1, ddr_init_pkg::ST_PRE2: begin
        if (tick) begin
          issue = 1'b1;
          next_cmd = ddr_init_pkg::CMD_PRECHARGE;
          next_addr = 13'h1 << ddr_init_pkg::AP_BIT;
          wait_val = ddr_init_pkg::tmr_type'(ddr_init_pkg::RP_CYC);
          next_ret = (state == ddr_init_pkg::ST_PRE1) ? ddr_init_pkg::ST_EXT_MODE : ddr_init_pkg::ST_REF1;
        end
      end
      ddr_init_pkg::ST_EXT_MODE: begin
        if (tick) begin
          issue = 1'b1;
          next_cmd = ddr_init_pkg::CMD_LOAD_MODE;
          next_ba = ddr_init_pkg::BA_EXT_MODE;
          next_addr = 13'(reduced_drive) << ddr_init_pkg::DRIVE_STRENGTH_BIT;
          wait_val = ddr_init_pkg::tmr_type'(ddr_init_pkg::MRD_CYC);
          next_ret = ddr_init_pkg::ST_BASE_MODE;
        end
      end
      ddr_init_pkg::ST_BASE_MODE, ddr_init_pkg::ST_DLL_CLEAR: begin
        if (tick) begin
          issue = 1'b1;
          next_cmd = ddr_init_pkg::CMD_LOAD_MODE;
          next_ba = ddr_init_pkg::BA_BASE_MODE;
          next_addr = base_mode;
          wait_val = ddr_init_pkg::tmr_type'(ddr_init_pkg::MRD_CYC);
          next_ret = ddr_init_pkg::ST_READY;
          if (state == ddr_init_pkg::ST_BASE_MODE) begin
            next_addr = base_mode | (13'h1 << ddr_init_pkg::DLL_RESET_BIT);
            dll_load = 1'b1;
            next_ret = ddr_init_pkg::ST_PRE2;
          end
        end
      end
      ddr_init_pkg::ST_REF1, ddr_init_pkg::ST_REF2: begin
        if (tick) begin
          issue = 1'b1;
          next_cmd = ddr_init_pkg::CMD_REFRESH;
          wait_val = ddr_init_pkg::tmr_type'(ddr_init_pkg::RFC_CYC);
          refi_load = 1'b1;
          next_ret = ddr_init_pkg::ST_REF2;
          if (state == ddr_init_pkg::ST_REF2) begin
            next_ret = dll_clear_en ? ddr_init_pkg::ST_DLL_CLEAR : ddr_init_pkg::ST_READY;
          end
        end
      end
      ddr_init_pkg::ST_WAIT: begin
        if (wait_done) begin
          next_state = ret;
        end
      end
      ddr_init_pkg::ST_READY: begin
        if (tick) begin
          next_ret = ddr_init_pkg::ST_READY;
          if (refi_done) begin
            issue = 1'b1;
            next_cmd = ddr_init_pkg::CMD_REFRESH;
            wait_val = ddr_init_pkg::tmr_type'(ddr_init_pkg::RFC_CYC);
            refi_load = 1'b1;
          end else if (relock_req) begin
            issue = 1'b1;
            relock_take = 1'b1;
            next_cmd = ddr_init_pkg::CMD_LOAD_MODE;
            next_ba = ddr_init_pkg::BA_BASE_MODE;
            next_addr = base_mode | (13'h1 << ddr_init_pkg::DLL_RESET_BIT);
            dll_load = 1'b1;
            wait_val = ddr_init_pkg::tmr_type'(ddr_init_pkg::MRD_CYC);
          end else if (cmd_pending && cmd_allowed) begin
            cmd_issue = 1'b1;
            next_cmd = cmd_code;
            next_ba = cmd_ba;
            next_addr = cmd_addr;
            ras_load = cmd_code == ddr_init_pkg::CMD_ACTIVE;
          end
        end
      end
      default: begin
        next_state = ddr_init_pkg::ST_IDLE;
      end
    endcase
    if (issue) begin
      wait_load = 1'b1;
      next_state = ddr_init_pkg::ST_WAIT;
    end
  end

  // clock enable never drops once raised, so every refresh sees it high
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= ddr_init_pkg::ST_IDLE;
      ret <= ddr_init_pkg::ST_IDLE;
      init_done <= 1'b0;
      o_cke <= 1'b0;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= ddr_init_pkg::CMD_NOP;
      o_ba <= 2'h0;
      o_addr <= 13'h0;
    end else begin
      state <= next_state;
      ret <= next_ret;
      if (state == ddr_init_pkg::ST_READY) begin
        init_done <= 1'b1;
      end
      o_cke <= next_cke;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= next_cmd;
      o_ba <= next_ba;
      o_addr <= next_addr;
    end
  end

endmodule

// >>> sim/ddr_init_properties.sv
/*
  Timing checks on the pins of the memory initialisation controller.
  Assumes it is bound to the controller and sees its ports only.
*/
`timescale 1ns/1ps
module ddr_init_properties #(
  parameter int POWERUP_CYC = 40
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // axi response
  input wire logic i_bready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  // memory pins
  input wire logic o_mem_ck,
  input wire logic o_mem_ck_n,
  input wire logic o_cke,
  input wire logic o_cs_n,
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n,
  input wire logic [1:0] o_ba,
  input wire logic [12:0] o_addr
);
  logic [3:0] cmd;
  int low_cnt;
  assign cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // cycles spent with clock enable low since reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      low_cnt <= 0;
    end else if (!o_cke) begin
      low_cnt <= low_cnt + 1;
    end
  end

  sequence s_nop4;
    (cmd == ddr_init_pkg::CMD_NOP)[*4];
  endsequence
  sequence s_ref4;
    (o_cke && cmd == ddr_init_pkg::CMD_NOP)[*4];
  endsequence
  sequence s_issue(logic [3:0] c);
    cmd == c && $past(cmd) == ddr_init_pkg::CMD_NOP;
  endsequence

  a_powerup_wait: assert property ($rose(o_cke) |-> low_cnt >= POWERUP_CYC)
    else $error("clock enable raised early");
  a_cke_held: assert property ($past(o_cke) |-> o_cke)
    else $error("clock enable dropped");
  a_nop_at_cke: assert property ($rose(o_cke) |-> s_nop4)
    else $error("no idle at clock enable");
  a_pre_all: assert property (s_issue(ddr_init_pkg::CMD_PRECHARGE) |-> o_addr[10] ##4 s_nop4)
    else $error("precharge wrong");
  a_ext_mode: assert property (s_issue(ddr_init_pkg::CMD_LOAD_MODE) ##0 o_ba == 2'h1 |->
    o_addr[12:2] == 11'h000 && !o_addr[0])
    else $error("extended mode wrong");
  a_mode_wait: assert property (s_issue(ddr_init_pkg::CMD_LOAD_MODE) |-> ##4 s_nop4)
    else $error("mode wait short");
  a_refresh_wait: assert property (s_issue(ddr_init_pkg::CMD_REFRESH) |-> ##4 s_ref4 ##1 s_ref4 ##1 s_ref4)
    else $error("refresh wait short");
  a_clock_pair: assert property (o_mem_ck_n == !o_mem_ck)
    else $error("clock pair wrong");
  a_clock_shape: assert property ($rose(o_mem_ck) |=> o_mem_ck ##1 !o_mem_ck[*2] ##1 o_mem_ck)
    else $error("clock shape wrong");
  a_pins_on_tick: assert property ($changed(cmd) |-> $past(o_mem_ck, 2) && !$past(o_mem_ck))
    else $error("command off falling clock");
  a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("response dropped");
endmodule

bind ddr_init_controller ddr_init_properties #(.POWERUP_CYC(POWERUP_CYC)) u_props (.*);

// >>> sim/ddr_device_model.sv
/*
  Behavioural single-rank memory seen at its pins.
  Assumes pins settle before each rising memory clock.
*/
`timescale 1ns/1ps
module ddr_device_model (
  // memory pins
  input wire logic i_rst,
  input wire logic i_ck,
  input wire logic i_cke,
  input wire logic [3:0] i_cmd,
  input wire logic [1:0] i_ba,
  input wire logic [12:0] i_addr,
  // observations
  output logic [12:0] o_ext,
  output logic [12:0] o_first,
  output logic [12:0] o_base,
  output int o_errs,
  output int o_reads,
  output int o_refs,
  output int o_gap
);
  int step, dll, act, gap;
  logic [3:0] want [6] = '{ddr_init_pkg::CMD_PRECHARGE, ddr_init_pkg::CMD_LOAD_MODE, ddr_init_pkg::CMD_LOAD_MODE,
    ddr_init_pkg::CMD_PRECHARGE, ddr_init_pkg::CMD_REFRESH, ddr_init_pkg::CMD_REFRESH};
  always @(posedge i_ck or posedge i_rst) begin
    if (i_rst) begin
      {step, dll, act, gap, o_errs, o_reads, o_refs, o_gap} = '0;
    end else if (i_cke && i_cmd != ddr_init_pkg::CMD_NOP) begin
      if (step < 6) begin
        // init order is strict
        if (i_cmd !== want[step] || (i_cmd == ddr_init_pkg::CMD_PRECHARGE && !i_addr[10])) o_errs++;
        if (step == 1) o_ext = i_addr;
        if (step == 2 && (i_ba != 2'h0 || !i_addr[8])) o_errs++;
        if (step == 2) {o_first, o_base, dll} = {i_addr, i_addr, 32'h0};
        if (i_cmd == ddr_init_pkg::CMD_REFRESH) {o_refs, gap} = {o_refs + 1, 32'h0};
        step++;
      end else begin
        // any valid command is taken once ready
        case (i_cmd)
          ddr_init_pkg::CMD_LOAD_MODE: if (i_ba == 2'h0) {o_base, dll} = {i_addr, i_addr[8] ? 32'h0 : dll};
          ddr_init_pkg::CMD_REFRESH: {o_refs, o_gap, gap} = {o_refs + 1, gap > o_gap ? gap : o_gap, 32'h0};
          ddr_init_pkg::CMD_ACTIVE: act = 0;
          ddr_init_pkg::CMD_READ: {o_reads, o_errs} = {o_reads + 1, o_errs + (dll < 200)};
          default: ;
        endcase
        if (i_cmd inside {ddr_init_pkg::CMD_READ, ddr_init_pkg::CMD_WRITE} && i_addr[10] && act < 2) o_errs++;
      end
    end
    if (!i_rst && i_cke) {dll, act, gap} = {dll + 1, act + 1, gap + 1};
  end
endmodule

// >>> sim/ddr_init_controller_tb.sv
/*
  Self-checking bench for the memory initialisation controller.
  Assumes the device model and checker are compiled with it.
*/
`timescale 1ns/1ps
module ddr_init_controller_tb;
  localparam int PU = 40;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_mem_ck, o_mem_ck_n, o_cke;
  logic o_cs_n, o_ras_n, o_cas_n, o_we_n;
  logic [1:0] o_bresp, o_rresp, o_ba, r;
  logic [31:0] o_rdata, v, w, m;
  logic [12:0] o_addr, m_ext, m_first, m_base;
  int m_errs, m_reads, m_refs, m_gap, bad_count, comparisons, seed, n, reads_exp;
  logic [3:0] ops [4] = '{ddr_init_pkg::CMD_ACTIVE, ddr_init_pkg::CMD_WRITE, ddr_init_pkg::CMD_READ,
    ddr_init_pkg::CMD_PRECHARGE};

  ddr_init_controller #(.POWERUP_CYC(PU)) dut (.*);
  ddr_device_model mem (
    .i_rst, .i_ck(o_mem_ck), .i_cke(o_cke), .i_cmd({o_cs_n, o_ras_n, o_cas_n, o_we_n}), .i_ba(o_ba),
    .i_addr(o_addr), .o_ext(m_ext), .o_first(m_first), .o_base(m_base), .o_errs(m_errs),
    .o_reads(m_reads), .o_refs(m_refs), .o_gap(m_gap)
  );

  initial forever #2.5 i_clock = ~i_clock;

  // ----------------------------------------------------------------
  // checks and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkr(input string s, input logic [1:0] e, input logic [1:0] g);
    chk(s, 32'(e), 32'(g));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'b111};
    do begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    r = o_bresp;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_clock);
    {i_araddr, i_arvalid, i_rready} <= {a, 2'b11};
    do begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    {v, r} = {o_rdata, o_rresp};
  endtask
  task automatic wst(input int b, input logic e);
    do rd(32'(ddr_init_pkg::OFS_STATUS)); while (v[b] !== e);
  endtask
  task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    wr(32'(ddr_init_pkg::OFS_CMD), {13'h0, a, b, c});
    wst(1, 1'b0);
  endtask
  task automatic summarize;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clock);
    bad_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 15230;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(32'(ddr_init_pkg::OFS_MODE));
    chk("mode reset", 32'h61, v);
    rd(32'(ddr_init_pkg::OFS_STATUS));
    chk("status reset", 32'h0, v);
    rd(32'h10);
    chkr("unmapped read", ddr_init_pkg::RESP_SLVERR, r);
    wr(32'h6, 32'h0);
    chkr("unaligned write", ddr_init_pkg::RESP_SLVERR, r);
    wr(32'(ddr_init_pkg::OFS_CMD), {28'h0, ddr_init_pkg::CMD_READ});
    chkr("early command", ddr_init_pkg::RESP_OKAY, r);
    m = $random(seed) & 32'h1eff;
    w = $random(seed);
    wr(32'(ddr_init_pkg::OFS_MODE), m);
    wr(32'(ddr_init_pkg::OFS_CTRL), {29'h0, 1'b1, w[0], 1'b1});
    n = 0;
    while (o_cke !== 1'b1) begin
      @(posedge i_clock);
      n++;
    end
    chk("powerup wait", 32'h1, 32'(n >= PU - 2));
    wst(0, 1'b1);
    chk("status ready", 32'h25, v & 32'h27);
    chk("ext mode", {30'h0, w[0], 1'b0}, 32'(m_ext));
    chk("dll reset mode", m | 32'h100, 32'(m_first));
    chk("dll clear mode", m, 32'(m_base));
    chk("init refreshes", 32'h2, m_refs);
    chk("early reads", 32'h0, m_reads);
    send(ddr_init_pkg::CMD_READ, 2'h0, 13'h0);
    send(ddr_init_pkg::CMD_ACTIVE, w[5:4], w[18:6]);
    send(ddr_init_pkg::CMD_WRITE, w[5:4], 13'h400);
    wr(32'(ddr_init_pkg::OFS_CTRL), 32'h8);
    wst(3, 1'b0);
    send(ddr_init_pkg::CMD_READ, 2'h1, 13'h0);
    reads_exp = 2;
    for (int k = 0; k < 8; k++) begin
      w = $random(seed);
      if (w[1:0] == 2'h3) w[16] = 1'b1;
      send(ops[w[1:0]], w[5:4], w[18:6]);
      if (ops[w[1:0]] == ddr_init_pkg::CMD_READ) reads_exp++;
    end
    repeat (2000) @(posedge i_clock);
    chk("reads issued", reads_exp, m_reads);
    chk("device faults", 32'h0, m_errs);
    chk("refresh gap", 32'h1, 32'(m_gap <= ddr_init_pkg::REFI_CYC / ddr_init_pkg::CK_DIV + 16));
    chk("refresh kept", 32'h1, 32'(m_refs > 3));
    summarize();
  end
endmodule
